// file: logic/usart_transmitter.v
// Transmit section of a serial port: data buffer, shift register, break,
// output forcing, status flags and two interrupt channels, APB registers.
// Assumes one 200 MHz clock, synchronous active-low reset, and an APB
// master on the same clock; no input crosses a clock domain.
`include "usart_tx_map.vh"
`default_nettype none

module usart_transmitter #(
	parameter DIV_W = 16  // Width of the shift clock divisor
) (
	input  wire        REF_CLK,
	input  wire        RST_N,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [7:0]  PADDR,
	input  wire [31:0] PWDATA,
	input  wire [3:0]  PSTRB,
	output reg  [31:0] PRDATA,
	output reg         PREADY,
	output reg         PSLVERR,
	output reg         TX_DATA,
	output reg         TX_DATA_OE,
	output reg         TX_LOOPBACK,
	output reg         TX_READY,
	output reg         RX_TURNAROUND,
	output reg         IRQ
);

	// ======================================================================
	// Engine states
	// ======================================================================
	localparam [2:0] ST_OFF   = 3'h0;  // Disabled, line forced
	localparam [2:0] ST_LEAD  = 3'h1;  // Enabled, waiting to send lead one
	localparam [2:0] ST_IDLE  = 3'h2;  // Enabled, shifter empty
	localparam [2:0] ST_SHIFT = 3'h3;  // Shifting a data or sync word
	localparam [2:0] ST_BREAK = 3'h4;  // Shifting all-zero break characters
	localparam [2:0] ST_BSTOP = 3'h5;  // Stop bit closing a break

	// ======================================================================
	// Declarations
	// ======================================================================
	reg  [2:0]       state;       // Engine state
	reg  [7:0]       buf_word;    // Transmit buffer
	reg              buf_full;    // Buffer holds an unsent word
	reg  [9:0]       shifter;     // Remaining bits of the frame
	reg  [3:0]       bits_left;   // Bits still to show after current one
	reg              line_bit;    // Bit currently on the line
	reg              be;          // Buffer-empty flag
	reg              ue;          // Underrun flag
	reg              endf;        // End-of-transmission flag
	reg              at;          // Auto-turnaround control
	reg              brk;         // Break request
	reg  [1:0]       force_sel;   // Output forcing field {high, low}
	reg              te;          // Transmitter enable
	reg  [7:0]       sync_char;   // Synchronous character
	reg              fmt_sync;    // Character format
	reg  [DIV_W-1:0] divisor;     // Shift clock divisor
	reg  [DIV_W-1:0] div_cnt;     // Divider counter
	reg              tick;        // One-cycle shift clock enable
	reg  [1:0]       ist;         // Sticky interrupt status
	reg  [1:0]       imask;       // Interrupt mask
	reg  [1:0]       ev;          // Interrupt events this cycle
	reg              ue_set;      // Underrun raised this cycle

	wire             done;        // APB transfer completes this edge
	wire             wr;          // Completing write
	wire             rd;          // Completing read
	wire [7:0]       idx;         // Register index from address
	wire             aligned;     // Word-aligned address
	wire             mapped;      // Address hits a register
	wire [9:0]       data_frame;  // Frame built from the buffer
	wire [9:0]       sync_frame;  // Frame built from the sync character
	wire [3:0]       frame_len;   // Bits per character in this format
	wire [7:0]       tsc_read;    // Status/control read image

	// ======================================================================
	// APB decode
	// ======================================================================
	// PREADY comes from a flop, so every transfer has one wait state
	assign done    = PSEL & PENABLE & PREADY;
	assign wr      = done & PWRITE;
	assign rd      = done & ~PWRITE;
	assign idx     = {2'h0, PADDR[7:2]};
	assign aligned = (PADDR[1:0] == 2'h0);
	assign mapped  = aligned & ((idx == `TSC_INDEX) | (idx == `DATA_INDEX) |
		(idx == `SYNC_INDEX) | (idx == `FMT_INDEX) | (idx == `DIV_INDEX) |
		(idx == `ISTAT_INDEX) | (idx == `IMASK_INDEX));

	// Frames go out LSB first; async frames carry start and stop bits
	assign data_frame = fmt_sync ? {2'h3, buf_word} : {1'b1, buf_word, 1'b0};
	assign sync_frame = {2'h3, sync_char};
	assign frame_len  = fmt_sync ? `SYNC_BITS : `ASYNC_BITS;

	assign tsc_read = {be, ue, at, endf, brk, force_sel, te};

	// ======================================================================
	// APB answer: ready, read data and error
	// ======================================================================
	// Raised one cycle into the access phase, dropped after completion
	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end else if (PSEL & PENABLE & ~PREADY) begin
			PREADY  <= 1'b1;
			PSLVERR <= ~mapped;  // Unmapped or misaligned address
			PRDATA  <= 32'h00000000;
			if (!PWRITE & aligned) begin
				case (idx)
					`TSC_INDEX:   PRDATA <= {24'h000000, tsc_read};
					`DATA_INDEX:  PRDATA <= {24'h000000, buf_word};
					`SYNC_INDEX:  PRDATA <= {24'h000000, sync_char};
					`FMT_INDEX:   PRDATA <= {31'h00000000, fmt_sync};
					`DIV_INDEX:   PRDATA <= {{(32 - DIV_W){1'b0}}, divisor};
					`ISTAT_INDEX: PRDATA <= {30'h00000000, ist};
					`IMASK_INDEX: PRDATA <= {30'h00000000, imask};
					default:      PRDATA <= 32'h00000000;
				endcase
			end
		end else begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end
	end

	// ======================================================================
	// Shift clock divider
	// ======================================================================
	// One tick per divisor+1 cycles; all line timing steps on this tick
	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			div_cnt <= {DIV_W{1'b0}};
			tick    <= 1'b0;
		end else if (div_cnt >= divisor) begin
			div_cnt <= {DIV_W{1'b0}};
			tick    <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 1'b1;
			tick    <= 1'b0;
		end
	end

	// ======================================================================
	// Configuration registers written by software
	// ======================================================================
	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			at        <= 1'b0;
			brk       <= 1'b0;
			force_sel <= `FORCE_HIZ;
			te        <= 1'b0;
			sync_char <= `SYNC_RESET;
			fmt_sync  <= 1'b0;
			divisor   <= `DIV_RESET;
			imask     <= 2'h0;
		end else if (wr & PSTRB[0]) begin
			case (idx)
				`TSC_INDEX: begin
					at        <= PWDATA[`TSC_AT];
					brk       <= PWDATA[`TSC_BRK];
					force_sel <= {PWDATA[`TSC_HI], PWDATA[`TSC_LO]};
					te        <= PWDATA[`TSC_TE];
				end
				`SYNC_INDEX:  sync_char <= PWDATA[7:0];
				`FMT_INDEX:   fmt_sync  <= PWDATA[`FMT_SYNC_BIT];
				`DIV_INDEX:   divisor   <= PWDATA[DIV_W-1:0];
				`IMASK_INDEX: imask     <= PWDATA[1:0];
				default: begin
					// Other indexes hold no configuration
				end
			endcase
		end
	end

	// ======================================================================
	// Transmit engine, buffer and status flags
	// ======================================================================
	// A single process owns the buffer and flags so that a data write and a
	// transfer in the same cycle resolve in one place.
	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			state         <= ST_OFF;
			buf_word      <= 8'h00;
			buf_full      <= 1'b0;
			shifter       <= 10'h3FF;
			bits_left     <= 4'h0;
			line_bit      <= 1'b1;
			be            <= 1'b1;
			ue            <= 1'b0;
			endf          <= 1'b0;
			ev            <= 2'h0;
			ue_set        <= 1'b0;
			RX_TURNAROUND <= 1'b0;
		end else begin
			ev            <= 2'h0;
			ue_set        <= 1'b0;
			RX_TURNAROUND <= 1'b0;

			// Enabling clears the end flag; a same-cycle stop below wins
			if (wr & PSTRB[0] & (idx == `TSC_INDEX) & PWDATA[`TSC_TE]) begin
				endf <= 1'b0;
			end

			// Engine steps only on the shift clock
			if (tick) begin
				case (state)
					ST_OFF: begin
						// Buffer may already hold a word here
						if (te) begin
							state <= ST_LEAD;
						end
					end
					ST_LEAD: begin
						if (!te) begin
							state <= ST_OFF;
							endf  <= 1'b1;
						end else begin
							// Single one ahead of the first word
							line_bit <= 1'b1;
							state    <= ST_IDLE;
						end
					end
					ST_IDLE, ST_SHIFT, ST_BSTOP: begin
						if (state == ST_SHIFT && bits_left != 4'h0) begin
							// Mid-character: next bit out
							line_bit  <= shifter[0];
							shifter   <= {1'b1, shifter[9:1]};
							bits_left <= bits_left - 1'b1;
						end else if (!te) begin
							// Word done or none in progress; buffer kept
							state         <= ST_OFF;
							endf          <= 1'b1;
							line_bit      <= 1'b1;
							RX_TURNAROUND <= at;
						end else if (brk && !fmt_sync) begin
							// Break starts at the boundary or at once
							state     <= ST_BREAK;
							line_bit  <= 1'b0;
							shifter   <= 10'h000;
							bits_left <= `ASYNC_BITS - 4'h1;
						end else if (buf_full) begin
							// Transfer buffer into the shifter
							state     <= ST_SHIFT;
							line_bit  <= data_frame[0];
							shifter   <= {1'b1, data_frame[9:1]};
							bits_left <= frame_len - 4'h1;
							buf_full  <= 1'b0;
							be        <= 1'b1;
							ev[`IRQ_BE] <= 1'b1;
						end else begin
							// Shifter ran dry before a new word arrived
							if (state != ST_IDLE) begin
								ue_set      <= 1'b1;
								ev[`IRQ_UE] <= 1'b1;
							end
							if (fmt_sync) begin
								// Keep sending the sync character
								state     <= ST_SHIFT;
								line_bit  <= sync_frame[0];
								shifter   <= {1'b1, sync_frame[9:1]};
								bits_left <= `SYNC_BITS - 4'h1;
							end else begin
								state    <= ST_IDLE;
								line_bit <= 1'b1;
							end
						end
					end
					ST_BREAK: begin
						if (bits_left != 4'h0) begin
							line_bit  <= 1'b0;
							bits_left <= bits_left - 1'b1;
						end else begin
							// Character boundary inside the break
							ev[`IRQ_UE] <= 1'b1;
							if (!te) begin
								// Stop with no closing stop bit
								state    <= ST_OFF;
								line_bit <= 1'b1;
								endf     <= 1'b1;
							end else if (brk) begin
								bits_left <= `ASYNC_BITS - 4'h1;
							end else begin
								// Break cleared: one stop bit, then resume
								state    <= ST_BSTOP;
								line_bit <= 1'b1;
							end
						end
					end
					default: begin
						state <= ST_OFF;
					end
				endcase
			end

			// Software writes the buffer; a write beats a same-cycle transfer
			if (wr & PSTRB[0] & (idx == `DATA_INDEX)) begin
				buf_word <= PWDATA[7:0];
				buf_full <= 1'b1;
				be       <= 1'b0;
			end

			// Underrun: status read or disable clears; a new event wins
			if (ue_set) begin
				ue <= 1'b1;
			end else if ((rd & (idx == `TSC_INDEX)) | ~te) begin
				ue <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Interrupt status, mask and request
	// ======================================================================
	// Status bits latch whether or not their channel is unmasked; the mask
	// only gates the request line, so polling software sees every event.
	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			ist <= 2'h0;
			IRQ <= 1'b0;
		end else begin
			if (wr & PSTRB[0] & (idx == `ISTAT_INDEX)) begin
				ist <= (ist & ~PWDATA[1:0]) | ev;
			end else begin
				ist <= ist | ev;
			end
			IRQ <= |(ist & imask);
		end
	end

	// ======================================================================
	// Line drive and handshake
	// ======================================================================
	// Forcing applies while disabled and until the lead bit goes out
	always @(posedge REF_CLK) begin
		if (!RST_N) begin
			TX_DATA     <= 1'b1;
			TX_DATA_OE  <= 1'b0;
			TX_LOOPBACK <= 1'b0;
			TX_READY    <= 1'b0;
		end else begin
			TX_LOOPBACK <= (force_sel == `FORCE_LOOP);
			TX_READY    <= te & ~buf_full;
			if (state == ST_OFF || state == ST_LEAD) begin
				case (force_sel)
					`FORCE_HIZ: begin
						TX_DATA    <= 1'b1;
						TX_DATA_OE <= 1'b0;
					end
					`FORCE_LOW: begin
						TX_DATA    <= 1'b0;
						TX_DATA_OE <= 1'b1;
					end
					`FORCE_HIGH: begin
						TX_DATA    <= 1'b1;
						TX_DATA_OE <= 1'b1;
					end
					default: begin
						// Loopback keeps the pin at mark
						TX_DATA    <= 1'b1;
						TX_DATA_OE <= 1'b1;
					end
				endcase
			end else begin
				TX_DATA    <= line_bit;
				TX_DATA_OE <= 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// file: logic/usart_tx_map.vh
// Register map, field positions, reset values and timing counts for the
// serial transmitter section.
// Assumes a 32-bit APB bus; each register sits at four times its index.
`ifndef USART_TX_MAP_VH
`define USART_TX_MAP_VH

// ==========================================================================
// Register indexes (byte address is four times the index)
// ==========================================================================
`define TSC_INDEX        8'h2D  // transmitter_status_control
`define DATA_INDEX       8'h2E  // serial_data_register
`define SYNC_INDEX       8'h2F  // synchronous character
`define FMT_INDEX        8'h30  // character format
`define DIV_INDEX        8'h31  // shift clock divisor
`define ISTAT_INDEX      8'h32  // sticky interrupt status, write one to clear
`define IMASK_INDEX      8'h33  // interrupt mask, same layout
`define ADDR_W           8      // Width of PADDR

// ==========================================================================
// transmitter_status_control fields
// ==========================================================================
`define TSC_BE           7      // tx_buffer_empty_flag, read only
`define TSC_UE           6      // tx_underrun_flag, cleared by read
`define TSC_AT           5      // auto_turnaround_bit
`define TSC_END          4      // end of transmission, read only
`define TSC_BRK          3      // break request
`define TSC_HI           2      // output forcing, high select
`define TSC_LO           1      // output forcing, low select
`define TSC_TE           0      // tx_enable_bit

// ==========================================================================
// Interrupt status / mask fields
// ==========================================================================
`define IRQ_BE           0      // buffer-empty channel
`define IRQ_UE           1      // underrun / end channel

// ==========================================================================
// Output forcing codes {high, low}
// ==========================================================================
`define FORCE_HIZ        2'h0
`define FORCE_LOW        2'h1
`define FORCE_HIGH       2'h2
`define FORCE_LOOP       2'h3

// ==========================================================================
// Reset values and frame sizes
// ==========================================================================
`define SYNC_RESET       8'h00
`define DIV_RESET        16'h0010
`define FMT_SYNC_BIT     0      // 1 = synchronous character format
`define ASYNC_BITS       4'hA   // start, eight data bits, stop
`define SYNC_BITS        4'h8   // eight data bits

`endif

// file: verification/usart_transmitter_props.sv
// Checker for the serial transmitter: APB answer timing and line shape.
// Assumes it is bound to the top module and sees its ports only.
`default_nettype none

module usart_transmitter_props #(
	parameter int BIT_MIN = 3  // Shortest bit time in cycles, divisor plus one
) (
	input wire logic        REF_CLK,
	input wire logic        RST_N,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        TX_DATA,
	input wire logic        TX_DATA_OE,
	input wire logic        TX_LOOPBACK,
	input wire logic        RX_TURNAROUND
);
	// ==========================================================
	// Helper: cycles since the line last changed
	// ==========================================================
	logic       last;  // Line value one edge ago
	logic [7:0] run;   // Saturating hold counter

	// Restarts on every change, so a short bit shows as a small count
	always @(posedge REF_CLK) begin
		last <= TX_DATA;
		if (!RST_N || TX_DATA != last) begin
			run <= 8'h01;
		end else if (run != 8'hFF) begin
			run <= run + 8'h01;
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	// ==========================================================
	// Assertions
	// ==========================================================
	a_pready_pulse: assert property (PREADY |=> !PREADY)
		else $error("pready held past one cycle");
	a_pready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("pready not one cycle after access");
	a_ready_quiet: assert property (!PSEL |=> !PREADY)
		else $error("pready without a request");
	a_slverr_ready: assert property (PSLVERR |-> PREADY)
		else $error("slave error outside answer");
	a_slverr_data: assert property (PSLVERR |-> PRDATA == 32'h0)
		else $error("refused read returned data");
	a_loop_high: assert property (TX_LOOPBACK |-> TX_DATA)
		else $error("loopback line not high");
	a_bit_hold: assert property ($changed(TX_DATA) && TX_DATA_OE && $past(TX_DATA_OE)
		|-> run >= BIT_MIN)
		else $error("line bit shorter than a tick");
	a_turn_pulse: assert property (RX_TURNAROUND |=> !RX_TURNAROUND)
		else $error("turnaround pulse too long");
endmodule

`default_nettype wire

// file: verification/serial_rx_model.sv
// Remote receiver on the transmit line: samples async frames mid-bit.
// Assumes a fixed divisor matching the one programmed by the bench.
`default_nettype none

module serial_rx_model (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        line,
	input wire logic        oe,
	input wire logic [15:0] div
);
	// ==========================================================
	// Received frames, {stop_bad, byte}
	// ==========================================================
	logic [8:0] q[$];

	// Needs a high-to-low edge, so a long break yields one entry only
	always begin : rx
		logic       prev;
		logic [7:0] b;
		int         i;
		prev = 1'b1;
		forever begin
			@(posedge clk);
			if (rst_n && oe && prev && !line) begin
				repeat ((div + 1) / 2) @(posedge clk);
				for (i = 0; i < 8; i++) begin
					repeat (div + 1) @(posedge clk);
					b[i] = line;  // Least significant bit first
				end
				repeat (div + 1) @(posedge clk);
				q.push_back({!line, b});
			end
			prev = line;
		end
	end
endmodule

`default_nettype wire

// file: verification/usart_transmitter_tb.sv
// Self-checking bench for the serial transmitter over APB.
// Assumes the receiver model and the register map header.
`include "usart_tx_map.vh"
`default_nettype none

module usart_transmitter_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        REF_CLK = 1'b0;
	logic        RST_N   = 1'b0;
	logic        PSEL    = 1'b0;
	logic        PENABLE = 1'b0;
	logic        PWRITE  = 1'b0;
	logic [7:0]  PADDR   = 8'h00;
	logic [31:0] PWDATA  = 32'h0;
	logic [3:0]  PSTRB   = 4'hF;  // Full strobes throughout
	wire  [31:0] PRDATA;
	wire         PREADY, PSLVERR, TX_DATA, TX_DATA_OE, TX_LOOPBACK, TX_READY;
	wire         RX_TURNAROUND, IRQ;
	int          err_count = 0;
	int          n_tests   = 0;
	int          k, z;
	int          n_turn    = 0;  // Turnaround pulses seen
	logic [15:0] sb;             // Line samples, one per bit time
	logic [31:0] rd;
	logic        er;
	logic [7:0]  d, d2;
	logic [7:0]  expq[$];

	always #2.5 REF_CLK = ~REF_CLK;
	// Pulses are one cycle wide, so counting them catches a missing or double one
	always @(posedge REF_CLK) if (RX_TURNAROUND === 1'b1) n_turn++;

	usart_transmitter uut (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .TX_DATA(TX_DATA), .TX_DATA_OE(TX_DATA_OE),
		.TX_LOOPBACK(TX_LOOPBACK), .TX_READY(TX_READY), .RX_TURNAROUND(RX_TURNAROUND),
		.IRQ(IRQ));
	serial_rx_model rx (.clk(REF_CLK), .rst_n(RST_N), .line(TX_DATA), .oe(TX_DATA_OE),
		.div(16'h0002));

	// ==========================================================
	// Tasks
	// ==========================================================
	task finish_test;
		$display("counts: %0d checks, %0d mismatches", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	task hang(input string nm);
		$display("mismatch %s expected done seen timeout", nm);
		err_count++;
		finish_test();
	endtask
	// One transfer; an idle cycle after it keeps drives one per step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= wd; PENABLE <= 1'b0;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin @(posedge REF_CLK); n++; end while (PREADY !== 1'b1 && n < 40);
		if (n >= 40) hang("pready");
		rd = PRDATA; er = PSLVERR;
		PSEL <= 1'b0; PENABLE <= 1'b0;
		@(posedge REF_CLK);
	endtask
	task wr(input logic [7:0] i, input logic [31:0] v); apb(1'b1, {i[5:0], 2'b00}, v); endtask
	task rg(input logic [7:0] i); apb(1'b0, {i[5:0], 2'b00}, 32'h0); endtask
	// Bounded wait: 0 handshake, 1 interrupt, 2 received frame
	task wait_hi(input int s);
		int n;
		n = 0;
		// Look one edge on, so a level launched by the last write has settled
		do begin
			@(posedge REF_CLK); n++;
			if (n > 2000) hang("wait");
		end while ((s == 0 ? TX_READY : s == 1 ? IRQ : 1'(rx.q.size() > 0)) !== 1'b1);
	endtask
	task rx_byte(input logic [7:0] e);
		wait_hi(2);
		chk("rx frame", {23'h0, 1'b0, e}, 32'(rx.q.pop_front()));
	endtask

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		void'($urandom(46));
		repeat (12) @(posedge REF_CLK);
		RST_N <= 1'b1;
		@(posedge REF_CLK);
		rg(`TSC_INDEX); chk("tsc reset", 32'h80, rd);
		apb(1'b0, 8'hFC, 32'h0); chk("unmapped err", 1, er);
		chk("unmapped data", 0, rd);
		$display("test reset done");
		// Slow ticks keep the forced state visible after enable
		wr(`DIV_INDEX, 32'hFF);
		for (k = 0; k < 4; k++) begin
			wr(`TSC_INDEX, 32'(k * 2 + 1));
			repeat (2) @(posedge REF_CLK);
			if (k != 0) chk("force line", 32'(k != 1), TX_DATA);
			if (k != 3) chk("force oe", 32'(k != 0), TX_DATA_OE);
			chk("loopback", 32'(k == 3), TX_LOOPBACK);
			wr(`TSC_INDEX, 32'h0);
			repeat (600) @(posedge REF_CLK);
		end
		wr(`DIV_INDEX, 32'h2);
		rx.q.delete();
		$display("test forcing done");
		wr(`IMASK_INDEX, 32'h2);
		d = $urandom;
		wr(`DATA_INDEX, d); rg(`TSC_INDEX); chk("be loaded", 0, rd[7]);
		wr(`TSC_INDEX, 32'h5);
		rx_byte(d);
		wait_hi(1);
		rg(`TSC_INDEX); chk("be after", 1, rd[7]); chk("underrun", 1, rd[6]);
		rg(`TSC_INDEX); chk("underrun read", 0, rd[6]);
		rg(`ISTAT_INDEX); chk("status", 3, rd);
		wr(`ISTAT_INDEX, 32'h3);
		repeat (3) @(posedge REF_CLK);
		chk("irq clear", 0, IRQ);
		$display("test single word done");
		// Block transfer paced by the handshake, error channel masked
		wr(`IMASK_INDEX, 32'h0);
		for (k = 0; k < 4; k++) begin
			d = $urandom; expq.push_back(d);
			wait_hi(0); wr(`DATA_INDEX, d);
		end
		for (k = 0; k < 4; k++) rx_byte(expq.pop_front());
		rg(`ISTAT_INDEX); chk("block pending", 3, rd);
		chk("irq masked", 0, IRQ);
		z = 0;
		for (k = 0; k < 30; k++) begin @(posedge REF_CLK); if (TX_DATA !== 1'b1) z++; end
		chk("idle mark", 0, z);
		$display("test block done");
		wr(`ISTAT_INDEX, 32'h3);
		wr(`TSC_INDEX, 32'hD);
		repeat (40) @(posedge REF_CLK);
		chk("break line", 0, TX_DATA);
		rg(`ISTAT_INDEX); chk("break end", 1, rd[1]);
		d = $urandom; wr(`DATA_INDEX, d);
		repeat (30) @(posedge REF_CLK);
		chk("break held", 0, TX_DATA);
		rx.q.delete();
		wr(`TSC_INDEX, 32'h5);
		rx_byte(d);
		repeat (10) @(posedge REF_CLK);
		rg(`TSC_INDEX); chk("after break", 1, rd[6]);
		wr(`TSC_INDEX, 32'hD); repeat (40) @(posedge REF_CLK);
		wr(`TSC_INDEX, 32'h5); repeat (80) @(posedge REF_CLK);
		rg(`TSC_INDEX); chk("break underrun", 1, rd[6]);
		rx.q.delete();
		$display("test break done");
		d = $urandom; d2 = $urandom;
		wr(`DATA_INDEX, d);
		repeat (12) @(posedge REF_CLK);
		wr(`DATA_INDEX, d2); wr(`TSC_INDEX, 32'h4); wr(`ISTAT_INDEX, 32'h3);
		rx_byte(d);
		repeat (60) @(posedge REF_CLK);
		chk("held word", 0, rx.q.size());
		rg(`TSC_INDEX); chk("be held", 0, rd[7]);
		rg(`ISTAT_INDEX); chk("no be event", 0, rd[0]);
		wr(`TSC_INDEX, 32'h5);
		rx_byte(d2);
		$display("test disable done");
		// Disable inside a break with a word waiting
		wr(`TSC_INDEX, 32'hD); d = 8'($urandom); wr(`DATA_INDEX, d);
		wr(`ISTAT_INDEX, 32'h3); repeat (20) @(posedge REF_CLK);
		wr(`TSC_INDEX, 32'h4); repeat (60) @(posedge REF_CLK);
		rg(`TSC_INDEX); chk("brk stop be", 0, rd[7]); chk("brk stop ue", 0, rd[6]);
		rg(`ISTAT_INDEX); chk("brk stop ev", 0, rd[0]);
		rx.q.delete(); wr(`TSC_INDEX, 32'h5);
		rx_byte(d);
		// Disable with an empty buffer, auto-turnaround set
		d = 8'($urandom); wr(`DATA_INDEX, d); repeat (12) @(posedge REF_CLK);
		wr(`TSC_INDEX, 32'h24); wr(`ISTAT_INDEX, 32'h3);
		rx_byte(d); repeat (20) @(posedge REF_CLK);
		rg(`ISTAT_INDEX); chk("no underrun", 0, rd);
		rg(`TSC_INDEX); chk("be stays", 1, rd[7]); chk("end flag", 1, rd[4]);
		chk("turnaround", 1, n_turn);
		$display("test empty disable done");
		// Sync format with nothing to send repeats the sync character
		wr(`TSC_INDEX, 32'h5);
		d = (8'($urandom) & 8'hFC) | 8'h01;
		wr(`SYNC_INDEX, d); wr(`FMT_INDEX, 32'h1); repeat (40) @(posedge REF_CLK);
		for (k = 0; k < 16; k++) begin repeat (3) @(posedge REF_CLK); sb[k] = TX_DATA; end
		z = 0;
		for (k = 0; k < 8; k++) if (8'({d, d} >> k) == sb[7:0]) z++;
		chk("sync repeat", 1, 32'(z > 0 && sb[15:8] == sb[7:0]));
		rg(`TSC_INDEX); chk("sync underrun", 1, rd[6]);
		wr(`FMT_INDEX, 32'h0); rx.q.delete();
		$display("test sync done");
		finish_test();
	end
endmodule

bind usart_transmitter usart_transmitter_props #(.BIT_MIN(3)) props (.REF_CLK(REF_CLK),
	.RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .TX_DATA(TX_DATA), .TX_DATA_OE(TX_DATA_OE),
	.TX_LOOPBACK(TX_LOOPBACK), .RX_TURNAROUND(RX_TURNAROUND));

`default_nettype wire
